//--- handler_bin_sort_trigger.sv
`timescale 1ns/100ps
`include "handler_defs.svh"
module handler_bin_sort_trigger #(
    parameter int VAL_W = `VAL_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // handler inputs, active low
    input wire logic ext_trigger_n,
    input wire logic hv_control_n,
    // configuration
    input wire logic external_trigger_mode,
    input wire handler_pkg::meas_mode_t meas_mode,
    input wire handler_pkg::disp_page_t disp_page,
    input wire logic two_limits,
    input wire logic flash_test,
    input wire logic [VAL_W-1:0] lower_limit,
    input wire logic [VAL_W-1:0] upper_limit,
    // measurement engine
    input wire logic meas_busy,
    input wire logic meas_done,
    input wire handler_pkg::result_t meas_result,
    output logic meas_start,
    output logic hv_enable,
    // handler outputs, active low
    output logic bin_out_0_n,
    output logic bin_out_1_n,
    output logic bin_out_2_n,
    output logic bin_out_3_n,
    output logic bin_out_4_n,
    output logic bin_out_5_n,
    output logic data_ready_n,
    output logic test_end_n,
    output logic trigger_armed_n
);
    logic trig_prev_q, trig_prev_d;
    logic [5:0] bin_q, bin_d;
    handler_pkg::stage_t stage_q, stage_d;
    logic start_q, start_d;
    logic trig_rise;
    logic [5:0] bin_sel;
    logic [VAL_W-1:0] val;

    assign val = meas_result.value[VAL_W-1:0];
    // pin is active low: rising edge of the pulse is a falling pin level
    assign trig_rise = trig_prev_q & ~ext_trigger_n;
    assign hv_enable = ~hv_control_n;

    always_comb begin
        bin_sel = `BIN_NONE;
        if (flash_test) begin
            // a flash-over and a too-low reading both reject the part
            if (meas_result.flash_fail || meas_result.low_fail) begin
                bin_sel = `BIN_LOW_FAIL;
            end else begin
                bin_sel = `BIN_PASS_RES;
            end
        end else if (disp_page == handler_pkg::page_seq) begin
            if (meas_result.low_fail) begin
                bin_sel = `BIN_LOW_FAIL;
            end else if (meas_result.high_fail) begin
                bin_sel = `BIN_HIGH_FAIL;
            end else begin
                bin_sel = `BIN_PASS_RES;
            end
        end else if (!two_limits) begin
            // resistance passes above limit, current passes below it
            if (meas_mode == handler_pkg::mode_res) begin
                bin_sel = (val > lower_limit) ? `BIN_PASS_RES : `BIN_LOW_FAIL;
            end else begin
                bin_sel = (val < lower_limit) ? `BIN_PASS_CUR : `BIN_HIGH_FAIL;
            end
        end else begin
            if (val <= lower_limit) begin
                bin_sel = `BIN_LOW_FAIL;
            end else if (val < upper_limit) begin
                bin_sel = `BIN_MID;
            end else begin
                bin_sel = `BIN_HIGH_FAIL;
            end
        end
    end

    // history resets to the idle pin level so a release cannot fake an edge
    always_comb begin
        trig_prev_d = ext_trigger_n;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            trig_prev_q <= 1'h1;
        end else begin
            trig_prev_q <= trig_prev_d;
        end
    end

    // a trigger is taken only from idle or once the last result is shown
    always_comb begin
        start_d = 1'h0;
        stage_d = stage_q;
        bin_d = bin_q;
        unique case (stage_q)
            handler_pkg::st_idle, handler_pkg::st_shown: begin
                if (external_trigger_mode && trig_rise && !meas_busy) begin
                    start_d = 1'h1;
                    stage_d = handler_pkg::st_measure;
                    bin_d = `BIN_NONE;
                end
            end
            handler_pkg::st_measure: begin
                // only a done pulse leaves; a stuck engine keeps the handler waiting
                if (meas_done) begin
                    bin_d = bin_sel;
                    stage_d = handler_pkg::st_latched;
                end
            end
            handler_pkg::st_latched: begin
                stage_d = handler_pkg::st_shown;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            start_q <= 1'h0;
            stage_q <= handler_pkg::st_idle;
            bin_q <= `BIN_NONE;
        end else begin
            start_q <= start_d;
            stage_q <= stage_d;
            bin_q <= bin_d;
        end
    end

    assign meas_start = start_q;
    assign {bin_out_5_n, bin_out_4_n, bin_out_3_n, bin_out_2_n, bin_out_1_n, bin_out_0_n} = ~bin_q;
    // both status lines mark the same moment; the handler may watch either
    assign data_ready_n = ~(stage_q == handler_pkg::st_shown);
    assign test_end_n = ~(stage_q == handler_pkg::st_shown);
    assign trigger_armed_n = ~(external_trigger_mode && stage_q != handler_pkg::st_measure
                               && stage_q != handler_pkg::st_latched);

    one_bin_a: assert property (@(posedge mclk) disable iff (rst)
        !data_ready_n |-> $onehot(bin_q)) else $error("bin not one-hot at ready");
    bin_before_ready_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(data_ready_n) |-> $stable(bin_q)) else $error("bin changed at ready");
    ready_order_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done)
        |=> data_ready_n ##1 (!data_ready_n && !test_end_n)) else $error("ready out of order");
    bins_clear_a: assert property (@(posedge mclk) disable iff (rst)
        meas_start |-> (bin_q == `BIN_NONE)) else $error("bins not cleared at start");

    trig_start_a: assert property (@(posedge mclk) disable iff (rst)
        (external_trigger_mode && trig_rise && !meas_busy
         && (stage_q == handler_pkg::st_idle || stage_q == handler_pkg::st_shown))
        |=> meas_start) else $error("trigger edge missed");
    no_int_start_a: assert property (@(posedge mclk) disable iff (rst)
        meas_start |-> $past(external_trigger_mode)) else $error("start without ext mode");
    start_pulse_a: assert property (@(posedge mclk) disable iff (rst)
        meas_start |=> !meas_start) else $error("start longer than one cycle");
    busy_refuse_a: assert property (@(posedge mclk) disable iff (rst)
        meas_busy |=> !meas_start) else $error("start while engine busy");
    hv_ctrl_a: assert property (@(posedge mclk) disable iff (rst)
        hv_enable == !hv_control_n) else $error("hv control mismatch");

    mid_bin_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done && !flash_test
         && disp_page == handler_pkg::page_test && two_limits
         && val > lower_limit && val < upper_limit) |=> !bin_out_2_n [*2])
        else $error("bin 2 not set between limits");
    low_bin_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done && !flash_test
         && disp_page == handler_pkg::page_test && two_limits && val <= lower_limit)
        |=> !bin_out_0_n) else $error("low interval not on bin 0");
    high_bin_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done && !flash_test
         && disp_page == handler_pkg::page_test && two_limits
         && val > lower_limit && val >= upper_limit) |=> !bin_out_4_n)
        else $error("high interval not on bin 4");
    res_pass_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done && !flash_test
         && disp_page == handler_pkg::page_test && !two_limits
         && meas_mode == handler_pkg::mode_res && val > lower_limit)
        |=> !bin_out_5_n) else $error("res pass not on bin 5");
    cur_pass_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done && !flash_test
         && disp_page == handler_pkg::page_test && !two_limits
         && meas_mode == handler_pkg::mode_cur && val < lower_limit)
        |=> !bin_out_0_n) else $error("cur pass not on bin 0");
    res_fail_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done && !flash_test
         && disp_page == handler_pkg::page_test && !two_limits
         && meas_mode == handler_pkg::mode_res && val <= lower_limit)
        |=> !bin_out_0_n) else $error("res fail not on bin 0");
    cur_fail_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done && !flash_test
         && disp_page == handler_pkg::page_test && !two_limits
         && meas_mode == handler_pkg::mode_cur && val >= lower_limit)
        |=> !bin_out_4_n) else $error("cur fail not on bin 4");

    seq_high_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done && !flash_test
         && disp_page == handler_pkg::page_seq
         && !meas_result.low_fail && meas_result.high_fail) |=> !bin_out_4_n)
        else $error("high fail not on bin 4");
    seq_low_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done && !flash_test
         && disp_page == handler_pkg::page_seq && meas_result.low_fail)
        |=> !bin_out_0_n) else $error("low fail not on bin 0");
    seq_pass_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done && !flash_test
         && disp_page == handler_pkg::page_seq
         && !meas_result.low_fail && !meas_result.high_fail) |=> !bin_out_5_n)
        else $error("sequence pass not on bin 5");
    flash_fail_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done && flash_test
         && (meas_result.flash_fail || meas_result.low_fail))
        |=> !bin_out_0_n [*2]) else $error("flash fail not on bin 0");
    flash_pass_a: assert property (@(posedge mclk) disable iff (rst)
        (stage_q == handler_pkg::st_measure && meas_done && flash_test
         && !meas_result.flash_fail && !meas_result.low_fail)
        |=> !bin_out_5_n) else $error("flash pass not on bin 5");
endmodule

//--- handler_bin_sort_trigger_tb_top.sv
`timescale 1ns/100ps
module handler_bin_sort_trigger_tb_top;
    logic mclk = 1'h0, rst = 1'h1, fire = 1'h0, hv_req = 1'h0, ext_mode = 1'h1;
    logic two = 1'h0, flash = 1'h0, busy = 1'h0, done = 1'h0;
    logic ext_trigger_n, hv_control_n, start, hv_en, rdy_n, end_n, armed_n;
    logic [5:0] bins_n;
    handler_pkg::meas_mode_t mode = handler_pkg::mode_res;
    handler_pkg::disp_page_t page = handler_pkg::page_test;
    handler_pkg::result_t res = '0;
    int err_total = 0, n_compared = 0, n_start = 0;
    handler_model handler_model_i (.mclk(mclk), .fire(fire), .hv_req(hv_req),
        .ext_trigger_n(ext_trigger_n), .hv_control_n(hv_control_n));
    handler_bin_sort_trigger handler_bin_sort_trigger_i (.mclk(mclk), .rst(rst),
        .ext_trigger_n(ext_trigger_n), .hv_control_n(hv_control_n),
        .external_trigger_mode(ext_mode), .meas_mode(mode), .disp_page(page),
        .two_limits(two), .flash_test(flash), .lower_limit(32'h64), .upper_limit(32'hC8),
        .meas_busy(busy), .meas_done(done), .meas_result(res), .meas_start(start),
        .hv_enable(hv_en), .bin_out_0_n(bins_n[0]), .bin_out_1_n(bins_n[1]),
        .bin_out_2_n(bins_n[2]), .bin_out_3_n(bins_n[3]), .bin_out_4_n(bins_n[4]),
        .bin_out_5_n(bins_n[5]), .data_ready_n(rdy_n), .test_end_n(end_n),
        .trigger_armed_n(armed_n));
    initial begin
        forever #5 mclk = ~mclk;
    end
    always @(negedge mclk) begin
        if (start === 1'h1) n_start++;
    end
    task automatic check(input logic [5:0] got, input logic [5:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse_trigger;
        @(posedge mclk);
        fire <= 1'h1;
        @(posedge mclk);
        fire <= 1'h0;
    endtask
    // cfg is {page, mode, two limits, flash}; flags are {low, high, flash}
    task automatic run(input logic [3:0] c, input logic [31:0] v, input logic [2:0] f,
                       input logic [5:0] exp);
        int k;
        @(posedge mclk);
        page <= handler_pkg::disp_page_t'(c[3]);
        mode <= handler_pkg::meas_mode_t'(c[2]);
        two <= c[1];
        flash <= c[0];
        pulse_trigger();
        k = 0;
        while (start !== 1'h1 && k < 20) begin
            @(negedge mclk);
            k++;
        end
        check({5'h00, start}, 6'h01);
        @(posedge mclk);
        busy <= 1'h1;
        done <= 1'h1;
        res <= {v, f};
        @(posedge mclk);
        done <= 1'h0;
        busy <= 1'h0;
        @(negedge mclk);
        check(~bins_n, exp);
        @(negedge mclk);
        check({3'h0, rdy_n, end_n, armed_n}, 6'h00);
        $display("case cfg %h value %h done at %0t", c, v, $time);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        hv_req <= 1'h1;
        repeat (2) @(negedge mclk);
        check({5'h00, hv_en}, 6'h01);
        run(4'h2, 32'h96, 3'h0, 6'h04);
        run(4'h2, 32'h32, 3'h0, 6'h01);
        run(4'h6, 32'hFA, 3'h0, 6'h10);
        run(4'h0, 32'h12C, 3'h0, 6'h20);
        run(4'h0, 32'h32, 3'h0, 6'h01);
        run(4'h4, 32'h32, 3'h0, 6'h01);
        run(4'h4, 32'h12C, 3'h0, 6'h10);
        run(4'h8, 32'h96, 3'h4, 6'h01);
        run(4'h8, 32'h96, 3'h2, 6'h10);
        run(4'h8, 32'h96, 3'h0, 6'h20);
        run(4'h3, 32'h96, 3'h1, 6'h01);
        run(4'h3, 32'h96, 3'h0, 6'h20);
        run(4'h3, 32'h96, 3'h4, 6'h01);
        @(posedge mclk);
        busy <= 1'h1;
        pulse_trigger();
        repeat (4) @(posedge mclk);
        busy <= 1'h0;
        ext_mode <= 1'h0;
        hv_req <= 1'h0;
        pulse_trigger();
        repeat (6) @(negedge mclk);
        check(n_start[5:0], 6'h0D);
        check({4'h0, hv_en, armed_n}, 6'h01);
        $display("refusal case done at %0t", $time);
        tally_and_finish();
    end
endmodule

//--- handler_defs.svh
`ifndef HANDLER_DEFS_SVH
`define HANDLER_DEFS_SVH
`define BIN_COUNT 6
`define VAL_W 32
`define BIN_PASS_RES 6'h20
`define BIN_PASS_CUR 6'h01
`define BIN_LOW_FAIL 6'h01
`define BIN_HIGH_FAIL 6'h10
`define BIN_MID 6'h04
`define BIN_NONE 6'h00
`endif

//--- handler_model.sv
`timescale 1ns/100ps
module handler_model (
    // bench requests
    input wire logic mclk,
    input wire logic fire,
    input wire logic hv_req,
    // handler pins, active low
    output logic ext_trigger_n = 1'h1,
    output logic hv_control_n = 1'h1
);
    // pins move only just after an edge, as a fixture's optocouplers would
    always @(posedge mclk) begin
        ext_trigger_n <= ~fire;
        hv_control_n <= ~hv_req;
    end
endmodule

//--- handler_pkg.sv
package handler_pkg;
    typedef enum logic {mode_res, mode_cur} meas_mode_t;
    typedef enum logic {page_test, page_seq} disp_page_t;
    typedef enum logic [1:0] {st_idle, st_measure, st_latched, st_shown} stage_t;
    typedef struct packed {
        logic [31:0] value;
        logic low_fail;
        logic high_fail;
        logic flash_fail;
    } result_t;
endpackage
